// >>> dv/cie_core_tb.sv
// Self-checking bench for the exec core
`include "cie_defines.svh"
module cie_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [7:0]        bus_din;
  logic [7:0]        ack_byte = 8'h00;
  logic              int_req_n = 1'b1;
  cie_pkg::cie_bus_s bus;
  int                n_errors = 0;
  int                samples_checked = 0;
  logic [31:0]       seed = 32'hf803c51f;
  logic [31:0]       rd;
  logic              err;
  logic [7:0]        v [9];
  logic [7:0]        nport;
  logic [7:0]        vb;
  logic [7:0]        m2;
  logic [15:0]       h1;
  logic [15:0]       h2;
  int                k;
  // Start, next start and T-states of each timed instruction
  int                ta [10] = '{0, 4, 6, 8, 16, 17, 23, 27, 29, 30};
  int                tn [10] = '{2, 6, 8, 9, 17, 18, 24, 29, 30, 32};
  int                tt [10] = '{12, 12, 11, 4, 11, 4, 6, 10, 6, 8};
  logic [7:0]        prog [33] = '{8'hed, 8'h48, 8'hed, 8'h40, 8'hed, 8'h78, 8'hdb, 8'h00,
    8'h04, 8'h0c, 8'hed, 8'h78, 8'hed, 8'h60, 8'hed, 8'h68, 8'h34, 8'hd9, 8'hed, 8'h60,
    8'hed, 8'h68, 8'h34, 8'h23, 8'h34, 8'hd9, 8'h34, 8'hdd, 8'h23, 8'h33, 8'hed, 8'h56, 8'h76};
  // Mode 2 routine: indexed increments (one negative displacement), index pair, mode 0, halt
  logic [7:0]        prog2 [12] = '{8'hdd, 8'h34, 8'h3f, 8'hfd, 8'h23, 8'hfd, 8'h34,
    8'h80, 8'hed, 8'h46, 8'h76, 8'h76};

  always #4 pclk = ~pclk;

  cie_core cie_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_din(bus_din), .int_req_n(int_req_n), .bus(bus));
  cie_mio cie_mio_i (.pclk(pclk), .bus(bus), .ack_byte(ack_byte), .bus_din(bus_din));

  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction

  function automatic logic [7:0] inc(input logic [7:0] x);
    return x + 8'h01;
  endfunction

  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic to();
    chk(32'h0, 32'h1);
    end_sim();
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 64);
    if (pready !== 1'b1) to();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wait_fetch(input int a);
    k = 0;
    while (!cie_mio_i.fetch_at.exists(a) && k < 20000) begin
      @(posedge pclk);
      k++;
    end
    if (!cie_mio_i.fetch_at.exists(a)) to();
  endtask

  // Request held until the acknowledge cycle shows, as a real device must
  task automatic irq(input logic [7:0] b);
    ack_byte <= b;
    int_req_n <= 1'b0;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (bus.iack !== 1'b1 && k < 4000);
    int_req_n <= 1'b1;
    if (bus.iack !== 1'b1) to();
  endtask

  initial begin
    for (int i = 0; i < 9; i++) v[i] = rnd();
    // Pointer values kept clear of code, vectors and stack
    v[5] = {3'b010, v[5][4:0]};
    v[7] = {3'b011, v[7][4:0]};
    v[8][0] = 1'b0;
    nport = rnd();
    vb = rnd() & 8'hfe;
    m2 = rnd();
    h1 = {v[5], v[6]};
    h2 = {v[7], v[8]};
    for (int i = 0; i < 9; i++) cie_mio_i.io_q.push_back(v[i]);
    for (int i = 0; i < 33; i++) cie_mio_i.mem[i] = prog[i];
    cie_mio_i.mem[7] = nport;
    cie_mio_i.mem[16'h0038] = 8'hed;
    cie_mio_i.mem[16'h0039] = 8'h5e;
    cie_mio_i.mem[16'h003a] = 8'h76;
    for (int i = 0; i < 12; i++) cie_mio_i.mem[16'h0100 + i] = prog2[i];
    // Index pairs both hold 1 here: targets 0040H and FF81H
    cie_mio_i.mem[16'h0040] = vb;
    cie_mio_i.mem[16'hff81] = m2;
    cie_mio_i.mem[{8'h02, vb}] = 8'h00;
    cie_mio_i.mem[{8'h02, vb} + 16'h0001] = 8'h01;
    cie_mio_i.mem[h1] = 8'hfe;
    cie_mio_i.mem[h2] = 8'h7f;
    cie_mio_i.mem[h2 + 16'h0001] = m2;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `CIE_A_CTRL, 32'h0);
    chk(rd, 32'(`CIE_CTRL_RV));
    apb(1'b0, 8'h10, 32'h0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, `CIE_A_IVEC, 32'h2);
    apb(1'b0, `CIE_A_IVEC, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, `CIE_A_CTRL, 32'h3);
    wait_fetch(32);
    tick(64);
    apb(1'b0, `CIE_A_STAT, 32'h0);
    chk(32'(rd[2:0]), 32'h3);
    for (int i = 0; i < 10; i++) begin
      k = cie_mio_i.fetch_at[tn[i]] - cie_mio_i.fetch_at[ta[i]];
      chk(32'(k), 32'(tt[i] * `CIE_TDIV));
    end
    chk(32'(cie_mio_i.io_log[1][7:0]), 32'(v[0]));
    chk(32'(cie_mio_i.io_log[2]), 32'({v[1], v[0]}));
    chk(32'(cie_mio_i.io_log[3]), 32'({v[2], nport}));
    chk(32'(cie_mio_i.io_log[4]), 32'({inc(v[1]), inc(v[0])}));
    chk(32'(cie_mio_i.mem[h1]), 32'(inc(inc(8'hfe))));
    chk(32'(cie_mio_i.mem[h2]), 32'(inc(8'h7f)));
    chk(32'(cie_mio_i.mem[h2 + 16'h0001]), 32'(inc(m2)));
    irq(8'hff);
    wait_fetch(58);
    chk(32'({cie_mio_i.mem[16'hffff], cie_mio_i.mem[16'hfffe]}), 32'h21);
    tick(64);
    apb(1'b0, `CIE_A_STAT, 32'h0);
    chk(32'(rd[2:0]), 32'h5);
    irq(vb);
    wait_fetch(266);
    chk(32'({cie_mio_i.mem[16'hfffd], cie_mio_i.mem[16'hfffc]}), 32'h3b);
    chk(32'(cie_mio_i.mem[16'h0040]), 32'(inc(vb)));
    chk(32'(cie_mio_i.mem[16'hff81]), 32'(inc(m2)));
    chk(32'(cie_mio_i.fetch_at[259] - cie_mio_i.fetch_at[256]), 32'(23 * `CIE_TDIV));
    chk(32'(cie_mio_i.fetch_at[261] - cie_mio_i.fetch_at[259]), 32'(10 * `CIE_TDIV));
    tick(64);
    apb(1'b0, `CIE_A_STAT, 32'h0);
    chk(32'(rd[2:0]), 32'h1);
    irq(8'h3c);
    wait_fetch(267);
    tick(64);
    apb(1'b0, `CIE_A_ACC, 32'h0);
    chk(32'(rd[7:0]), 32'(inc(v[4])));
    k = cie_mio_i.fetch_at.num();
    tick(400);
    chk(32'(cie_mio_i.fetch_at.num()), 32'(k));
    end_sim();
  end
endmodule // cie_core_tb

// >>> dv/cie_mio.sv
// Memory and port model on the far side of the exec core bus
module cie_mio (
  input  wire logic              pclk,
  input  wire cie_pkg::cie_bus_s bus,
  input  wire logic [7:0]        ack_byte,
  output logic      [7:0]        bus_din
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [0:65535];
  logic [7:0]  io_q [$];
  logic [15:0] io_log [$];
  int          fetch_at [int];
  logic [7:0]  io_cur = 8'h00;
  logic [7:0]  last = 8'h00;
  logic        iord_d = 1'b0;
  int          clk_n = 0;
  int          m1_len = 0;

  // Idle lines carry the inverse of the last byte so stale data never matches
  always_comb begin
    if (bus.mrd) bus_din = mem[bus.addr];
    else if (bus.iord) bus_din = io_cur;
    else if (bus.iack) bus_din = ack_byte;
    else bus_din = ~last;
  end

  always @(posedge pclk) begin
    clk_n <= clk_n + 1;
    iord_d <= bus.iord;
    m1_len <= (bus.m1 && m1_len < 15) ? m1_len + 1 : 0;
    if (bus.mrd || bus.iord || bus.iack) last <= bus_din;
    if (bus.mwr) mem[bus.addr] <= bus.dout;
    if (bus.iord && !iord_d) begin
      io_log.push_back(bus.addr);
      io_cur <= io_q.pop_front();
    end
    // An M1 level held past one fetch length counts as the next fetch
    if (bus.m1 && !bus.iack && m1_len == 0 && !fetch_at.exists(int'(bus.addr)))
      fetch_at[int'(bus.addr)] = clk_n;
  end
endmodule // cie_mio

// >>> rtl/cie_core.sv
// Exec core: halt, bank swap, interrupt modes, port input, increments
// Behaviour
// - Halt takes 4 T-states, then nothing runs until an interrupt is taken
// - Interrupts are still taken while halted
// - Bank swap exchanges three pairs with alternates in 4 T-states, flags kept
// - Mode 0 executes the byte the device supplies; mode selects take 8 T-states
// - Mode 1 answers an interrupt with a call to 0038H
// - Mode 2 reads its call target at vector page byte and device byte
// - Immediate port input: port on A0-A7, accumulator on A8-A15, 11 T-states
// - Indirect port input: port register low, counter high, 12 T-states
// - Indirect input flags: S, Z, even parity; H, N cleared; carry kept
// - Register field 000-101 general registers, 111 accumulator; increment 4 T-states
// - Memory increment: read, write value plus one, 11 T-states
// - 8-bit increment flags: S, Z, bit 3 carry, 7FH overflow, N clear
// - Indexed increment adds signed displacement, 23 T-states
// - Index pair increment takes 10 T-states, flags kept
// - Pair field 00 counter, 01 target, 10 pointer, 11 stack top; flags kept
// - Pair increment completes in 6 T-states
`include "cie_defines.svh"
module cie_core (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  bus_din,
  input  wire logic        int_req_n,
  output cie_pkg::cie_bus_s bus
);
  logic [7:0]  rf [0:7];
  logic [7:0]  alt [0:5];
  logic [15:0] pc, stack_top_pointer, first_index_pair, second_index_pair;
  logic [15:0] addr, vec;
  logic [7:0]  f, ivec, dout;
  logic [1:0]  pfx, im, ctrl;
  logic [2:0]  div, tcount;
  logic        halted, irq_s1, irq_s2;
  cie_pkg::cie_mc_e mc;

  function automatic logic [2:0] mc_len(input cie_pkg::cie_mc_e m);
    case (m)
      cie_pkg::MC_FETCH, cie_pkg::MC_OP2: mc_len = `CIE_T_M1;
      cie_pkg::MC_DISP, cie_pkg::MC_IMM, cie_pkg::MC_VECL,
      cie_pkg::MC_VECH: mc_len = `CIE_T_MR;
      cie_pkg::MC_MRX: mc_len = `CIE_T_MRX;
      cie_pkg::MC_MW, cie_pkg::MC_PUSHH, cie_pkg::MC_PUSHL: mc_len = `CIE_T_MW;
      cie_pkg::MC_IORD: mc_len = `CIE_T_IO;
      cie_pkg::MC_ADD: mc_len = `CIE_T_ADD;
      cie_pkg::MC_X2: mc_len = `CIE_T_X2;
      cie_pkg::MC_ACK: mc_len = `CIE_T_ACK;
      default: mc_len = 3'd1;
    endcase
  endfunction

  // Flag byte layout S Z - H - P/V N C
  function automatic logic [7:0] inc_flags(input logic [7:0] v, input logic c);
    logic [7:0] r;
    r = v + 8'h01;
    inc_flags = {r[7], r == 8'h00, 1'b0, v[3:0] == 4'hf, 1'b0, v == 8'h7f, 1'b0, c};
  endfunction

  function automatic logic [7:0] in_flags(input logic [7:0] v, input logic c);
    in_flags = {v[7], v == 8'h00, 1'b0, 1'b0, 1'b0, ~^v, 1'b0, c};
  endfunction

  wire        tick     = div == 3'd0;
  wire        mend     = tick && tcount == mc_len(mc) - 3'd1;
  wire [7:0]  op       = bus_din;
  wire        base_end = mc == cie_pkg::MC_FETCH || (mc == cie_pkg::MC_ACK && im == 2'd0);
  wire [15:0] pc_inc   = pc + 16'h0001;
  wire [15:0] pc_nx    = (mc == cie_pkg::MC_FETCH) ? pc_inc : pc;
  wire        irq_take = irq_s2 && ctrl[`CIE_IEN];
  wire        is_ed    = pfx == 2'd1;
  wire [15:0] xr       = pfx[0] ? second_index_pair : first_index_pair;
  wire [15:0] xaddr    = xr + {{8{op[7]}}, op};
  wire        op_incr  = op[7:6] == 2'b00 && op[2:0] == 3'b100 && op[5:3] != 3'b110;
  wire        op_incss = op[7:6] == 2'b00 && op[3:0] == 4'b0011;
  wire        op_inrc  = op[7:6] == 2'b01 && op[2:0] == 3'b000;
  wire        run      = ctrl[`CIE_RUN];
  cie_pkg::cie_mc_e nxt;
  assign nxt = irq_take ? cie_pkg::MC_ACK : run ? cie_pkg::MC_FETCH : cie_pkg::MC_IDLE;

  // Strobes are levels for the whole machine cycle; read data is taken at its last T-state
  assign bus.addr = addr;
  assign bus.dout = dout;
  assign bus.m1   = mc == cie_pkg::MC_FETCH || mc == cie_pkg::MC_OP2;
  assign bus.mrd  = bus.m1 || mc == cie_pkg::MC_DISP || mc == cie_pkg::MC_IMM ||
                    mc == cie_pkg::MC_MRX || mc == cie_pkg::MC_VECL || mc == cie_pkg::MC_VECH;
  assign bus.mwr  = mc == cie_pkg::MC_MW || mc == cie_pkg::MC_PUSHH || mc == cie_pkg::MC_PUSHL;
  assign bus.iord = mc == cie_pkg::MC_IORD;
  assign bus.iack = mc == cie_pkg::MC_ACK;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div    <= 3'd0;
      irq_s1 <= 1'b0;
      irq_s2 <= 1'b0;
    end else begin
      div    <= (div == `CIE_TDIV - 3'd1) ? 3'd0 : div + 3'd1;
      irq_s1 <= ~int_req_n;
      irq_s2 <= irq_s1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) rf[i] <= 8'h00;
      for (int i = 0; i < 6; i++) alt[i] <= 8'h00;
      pc <= `CIE_PC_RV;
      stack_top_pointer <= `CIE_SP_RV;
      first_index_pair <= 16'h0000;
      second_index_pair <= 16'h0000;
      addr <= 16'h0000;
      vec <= 16'h0000;
      f <= 8'h00;
      dout <= 8'h00;
      pfx <= 2'd0;
      im <= 2'd0;
      tcount <= 3'd0;
      halted <= 1'b0;
      mc <= cie_pkg::MC_IDLE;
    end else if (tick && !mend) begin
      tcount <= tcount + 3'd1;
    end else if (mend) begin
      tcount <= 3'd0;
      if (base_end) begin
        // Mode 0 treats the acknowledge byte as the opcode
        pc <= pc_nx;
        pfx <= 2'd0;
        mc <= nxt;
        addr <= pc_nx;
        if (op == `CIE_OP_PED || op == `CIE_OP_PDD || op == `CIE_OP_PFD) begin
          pfx <= (op == `CIE_OP_PED) ? 2'd1 : (op == `CIE_OP_PDD) ? 2'd2 : 2'd3;
          mc <= cie_pkg::MC_OP2;
        end else if (op == `CIE_OP_HALT) begin
          halted <= 1'b1;
          mc <= cie_pkg::MC_HALT;
        end else if (op == `CIE_OP_SWAP) begin
          for (int i = 0; i < 6; i++) begin
            rf[i] <= alt[i];
            alt[i] <= rf[i];
          end
        end else if (op == `CIE_OP_INA) begin
          mc <= cie_pkg::MC_IMM;
        end else if (op == `CIE_OP_INCM) begin
          addr <= {rf[4], rf[5]};
          mc <= cie_pkg::MC_MRX;
        end else if (op_incr) begin
          rf[op[5:3]] <= rf[op[5:3]] + 8'h01;
          f <= inc_flags(rf[op[5:3]], f[0]);
        end else if (op_incss) begin
          vec <= {14'h0000, op[5:4]};
          mc <= cie_pkg::MC_X2;
        end
      end else begin
        case (mc)
          cie_pkg::MC_IDLE: begin
            addr <= pc;
            mc <= nxt;
          end
          cie_pkg::MC_HALT: begin
            if (irq_take) begin
              halted <= 1'b0;
              mc <= cie_pkg::MC_ACK;
            end
          end
          cie_pkg::MC_OP2: begin
            pc <= pc_inc;
            addr <= pc_inc;
            mc <= nxt;
            vec <= 16'h0004;
            if (is_ed) begin
              if (op == `CIE_OP_IM0) im <= 2'd0;
              else if (op == `CIE_OP_IM1) im <= 2'd1;
              else if (op == `CIE_OP_IM2) im <= 2'd2;
              else if (op_inrc) begin
                addr <= {rf[0], rf[1]};
                vec <= {13'h0000, op[5:3]};
                mc <= cie_pkg::MC_IORD;
              end
            end else if (op == `CIE_OP_INCX) begin
              mc <= cie_pkg::MC_X2;
            end else if (op == `CIE_OP_INCM) begin
              mc <= cie_pkg::MC_DISP;
            end
          end
          cie_pkg::MC_DISP: begin
            pc <= pc_inc;
            addr <= xaddr;
            mc <= cie_pkg::MC_ADD;
          end
          cie_pkg::MC_ADD: mc <= cie_pkg::MC_MRX;
          cie_pkg::MC_MRX: begin
            dout <= op + 8'h01;
            f <= inc_flags(op, f[0]);
            mc <= cie_pkg::MC_MW;
          end
          cie_pkg::MC_IMM: begin
            pc <= pc_inc;
            addr <= {rf[7], op};
            vec <= 16'h0007;
            mc <= cie_pkg::MC_IORD;
          end
          cie_pkg::MC_IORD: begin
            // Field 110 of the indirect form only updates the flags
            if (vec[2:0] != 3'b110) rf[vec[2:0]] <= op;
            if (is_ed) f <= in_flags(op, f[0]);
            addr <= pc;
            mc <= nxt;
          end
          cie_pkg::MC_X2: begin
            if (pfx == 2'd2) first_index_pair <= first_index_pair + 16'h0001;
            else if (pfx == 2'd3) second_index_pair <= second_index_pair + 16'h0001;
            else if (vec[1:0] == 2'd0) {rf[0], rf[1]} <= {rf[0], rf[1]} + 16'h0001;
            else if (vec[1:0] == 2'd1) {rf[2], rf[3]} <= {rf[2], rf[3]} + 16'h0001;
            else if (vec[1:0] == 2'd2) {rf[4], rf[5]} <= {rf[4], rf[5]} + 16'h0001;
            else stack_top_pointer <= stack_top_pointer + 16'h0001;
            addr <= pc;
            mc <= nxt;
          end
          cie_pkg::MC_ACK: begin
            addr <= stack_top_pointer - 16'h0001;
            dout <= pc[15:8];
            vec <= `CIE_RST38;
            mc <= cie_pkg::MC_PUSHH;
            if (im == 2'd2) begin
              addr <= {ivec, op};
              mc <= cie_pkg::MC_VECL;
            end
          end
          cie_pkg::MC_VECL: begin
            vec[7:0] <= op;
            addr <= addr + 16'h0001;
            mc <= cie_pkg::MC_VECH;
          end
          cie_pkg::MC_VECH: begin
            vec[15:8] <= op;
            addr <= stack_top_pointer - 16'h0001;
            dout <= pc[15:8];
            mc <= cie_pkg::MC_PUSHH;
          end
          cie_pkg::MC_PUSHH: begin
            addr <= stack_top_pointer - 16'h0002;
            dout <= pc[7:0];
            mc <= cie_pkg::MC_PUSHL;
          end
          cie_pkg::MC_PUSHL: begin
            stack_top_pointer <= stack_top_pointer - 16'h0002;
            pc <= vec;
            addr <= vec;
            mc <= run ? cie_pkg::MC_FETCH : cie_pkg::MC_IDLE;
          end
          default: begin
            addr <= pc;
            mc <= nxt;
          end
        endcase
      end
    end
  end

  // Register slave: no wait states, unmapped offsets answer with an error
  wire acc_ph = psel && penable;
  wire hit    = paddr == `CIE_A_CTRL || paddr == `CIE_A_STAT ||
                paddr == `CIE_A_IVEC || paddr == `CIE_A_ACC;
  assign pready  = 1'b1;
  assign pslverr = acc_ph && !hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `CIE_CTRL_RV;
      ivec <= 8'h00;
      prdata <= 32'h0000_0000;
    end else begin
      if (acc_ph && pwrite && paddr == `CIE_A_CTRL) ctrl <= pwdata[1:0];
      if (acc_ph && pwrite && paddr == `CIE_A_IVEC) ivec <= pwdata[7:0];
      if (psel && !penable) begin
        if (paddr == `CIE_A_CTRL) prdata <= {30'h0, ctrl};
        else if (paddr == `CIE_A_STAT) prdata <= {pc, 13'h0, im, halted};
        else if (paddr == `CIE_A_IVEC) prdata <= {24'h0, ivec};
        else if (paddr == `CIE_A_ACC) prdata <= {24'h0, rf[7]};
        else prdata <= 32'h0000_0000;
      end
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  halt_stays_a: assert property (mc == cie_pkg::MC_HALT && !irq_take |=> halted)
    else $error("halt left without interrupt");
  halt_wakes_a: assert property (mc == cie_pkg::MC_HALT && mend && irq_take
    |=> mc == cie_pkg::MC_ACK && !halted)
    else $error("halt ignored interrupt");
  swap_flags_a: assert property (mend && base_end && op == `CIE_OP_SWAP
    |=> rf[0] == $past(alt[0]) && alt[5] == $past(rf[5]) && $stable(f))
    else $error("bank swap wrong");
  mode_hold_a: assert property (!(mend && mc == cie_pkg::MC_OP2) |=> $stable(im))
    else $error("mode changed without select");
  in_addr_a: assert property (bus.iord && pfx == 2'd0 |-> addr[15:8] == rf[7])
    else $error("port high byte not accumulator");
  in_flags_a: assert property (mend && bus.iord && is_ed
    |=> f[4] == 1'b0 && f[1] == 1'b0 && f[0] == $past(f[0]) && f[2] == ~^$past(op))
    else $error("input flags wrong");
  inc_mem_a: assert property (mend && mc == cie_pkg::MC_MRX
    |=> bus.mwr && dout == $past(op) + 8'h01 && f[2] == ($past(op) == 8'h7f))
    else $error("memory increment wrong");
  rst38_a: assert property (mend && mc == cie_pkg::MC_ACK && im == 2'd1
    |=> vec == `CIE_RST38 && mc == cie_pkg::MC_PUSHH)
    else $error("mode 1 target wrong");
  pair_flags_a: assert property (mend && mc == cie_pkg::MC_X2 |=> $stable(f))
    else $error("pair increment touched flags");
endmodule // cie_core

// >>> rtl/cie_defines.svh
// Offsets, reset values, opcodes and T-state counts for the exec core
`ifndef CIE_DEFINES_SVH
`define CIE_DEFINES_SVH
`define CIE_A_CTRL  8'h00
`define CIE_A_STAT  8'h04
`define CIE_A_IVEC  8'h08
`define CIE_A_ACC   8'h0c
`define CIE_RUN     0
`define CIE_IEN     1
`define CIE_CTRL_RV 2'b00
`define CIE_PC_RV   16'h0000
`define CIE_SP_RV   16'hffff
`define CIE_RST38   16'h0038
`define CIE_TDIV    3'd4
`define CIE_T_M1    3'd4
`define CIE_T_MR    3'd3
`define CIE_T_MRX   3'd4
`define CIE_T_MW    3'd3
`define CIE_T_IO    3'd4
`define CIE_T_ADD   3'd5
`define CIE_T_X2    3'd2
`define CIE_T_ACK   3'd4
`define CIE_OP_HALT 8'h76
`define CIE_OP_SWAP 8'hd9
`define CIE_OP_INA  8'hdb
`define CIE_OP_INCM 8'h34
`define CIE_OP_INCX 8'h23
`define CIE_OP_PED  8'hed
`define CIE_OP_PDD  8'hdd
`define CIE_OP_PFD  8'hfd
`define CIE_OP_IM0  8'h46
`define CIE_OP_IM1  8'h56
`define CIE_OP_IM2  8'h5e
`endif

// >>> rtl/cie_pkg.sv
// Types shared by the exec core
package cie_pkg;
  typedef enum logic [3:0] {
    MC_IDLE, MC_FETCH, MC_OP2, MC_DISP, MC_ADD, MC_IMM, MC_MRX, MC_MW,
    MC_IORD, MC_X2, MC_HALT, MC_ACK, MC_VECL, MC_VECH, MC_PUSHH, MC_PUSHL
  } cie_mc_e;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  dout;
    logic        mrd;
    logic        mwr;
    logic        iord;
    logic        m1;
    logic        iack;
  } cie_bus_s;
endpackage
